/* verilog/dcc_pkg.sv */
// shared constants for the dual comparator control registers
package dcc_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 8;

    // register offsets on the special function register port
    localparam logic [AW-1:0] ADDR_CMP0_CONTROL = 8'h9a;
    localparam logic [AW-1:0] ADDR_CMP0_MODE    = 8'h9b;
    localparam logic [AW-1:0] ADDR_CMP1_CONTROL = 8'h9d;

    // control register field positions
    localparam int unsigned CTL_ON_BIT     = 7;
    localparam int unsigned CTL_RESULT_BIT = 6;
    localparam int unsigned CTL_RISE_BIT   = 5;
    localparam int unsigned CTL_FALL_BIT   = 4;
    localparam int unsigned CTL_POSH_MSB   = 3;
    localparam int unsigned CTL_POSH_LSB   = 2;
    localparam int unsigned CTL_NEGH_MSB   = 1;
    localparam int unsigned CTL_NEGH_LSB   = 0;

    // mode register field positions
    localparam int unsigned MD_RISE_IE_BIT = 5;
    localparam int unsigned MD_FALL_IE_BIT = 4;
    localparam int unsigned MD_SPEED_MSB   = 1;
    localparam int unsigned MD_SPEED_LSB   = 0;

    // reset values
    localparam logic [DW-1:0] RST_CONTROL = 8'h00;
    localparam logic [DW-1:0] RST_MODE    = 8'h02;
    localparam logic [1:0]    RST_SPEED   = 2'h2;
    localparam logic [1:0]    RST_HYST    = 2'h0;
    localparam logic [DW-1:0] RD_UNMAPPED = 8'h00;

    // hysteresis codes (analog core decodes them)
    typedef enum logic [1:0] {
        DCC_HYST_OFF  = 2'b00,
        DCC_HYST_LOW  = 2'b01,
        DCC_HYST_MID  = 2'b10,
        DCC_HYST_HIGH = 2'b11
    } dcc_hyst_t;
endpackage

/* verilog/dcc_edge_if.sv */
// edge flag carrier between the register bank and one edge detector
`timescale 1ns/10ps
interface dcc_edge_if;
    logic wr_flags;
    logic wr_rise;
    logic wr_fall;
    logic result;
    logic rise_evt;
    logic fall_evt;
    logic rise_flag;
    logic fall_flag;

    modport det  (input wr_flags, wr_rise, wr_fall,
                  output result, rise_evt, fall_evt, rise_flag, fall_flag);
    modport regs (output wr_flags, wr_rise, wr_fall,
                  input result, rise_evt, fall_evt, rise_flag, fall_flag);
endinterface

/* verilog/dcc_edge_det.sv */
// synchroniser, edge detector and sticky edge flags for one comparator
`timescale 1ns/10ps
module dcc_edge_det (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // raw comparator output, asynchronous
    input  wire logic raw_i,
    // register side
    dcc_edge_if.det   edge_if
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise_ff;
    logic fall_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= raw_i;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign edge_if.result   = sync2_ff;
    assign edge_if.rise_evt = sync2_ff & ~prev_ff;
    assign edge_if.fall_evt = ~sync2_ff & prev_ff;

    // an edge in the write cycle wins over the written zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            rise_ff <= edge_if.rise_evt
                     | (edge_if.wr_flags ? edge_if.wr_rise : rise_ff);
            fall_ff <= edge_if.fall_evt
                     | (edge_if.wr_flags ? edge_if.wr_fall : fall_ff);
        end
    end

    assign edge_if.rise_flag = rise_ff;
    assign edge_if.fall_flag = fall_ff;

    a_rise_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        edge_if.rise_evt |=> rise_ff) else $error("rising edge did not set flag");
    a_fall_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        edge_if.fall_evt |=> fall_ff) else $error("falling edge did not set flag");
    a_flag_stays_set: assert property (@(posedge clk_i) disable iff (reset_i)
        (rise_ff && !edge_if.wr_flags) |=> rise_ff) else $error("rise flag dropped alone");
    a_edge_from_raw: assert property (@(posedge clk_i) disable iff (reset_i)
        (!$past(raw_i, 3) && $past(raw_i, 2)) |-> edge_if.rise_evt)
        else $error("raw rise not seen after sync");
endmodule

/* verilog/dcc_regs.sv */
// dual comparator control and status registers on the system clock
//
// How it works
// - control0 bit 7 powers comparator A on; resets to 0.
// - control0 bit 6 is read-only comparator A result.
// - comparator A rising edge sets bit 5 until software writes 0.
// - comparator A falling edge sets bit 4 until software clears it.
// - bits 3:2 positive hysteresis code goes to the analog core.
// - bits 1:0 negative hysteresis code of comparator A goes to the core.
// - mode bit 5 enables interrupt request while rise flag set.
// - mode bit 4 enables interrupt request while fall flag set.
// - mode bits 1:0 select speed/power for core; reset value 10.
// - mode bits 7:6 and 3:2 read zero, writes ignored.
// - control1 has same layout: enable bit 7, result bit 6.
// - comparator B edge flags bits 5,4 sticky until software clears.
// - comparator B negative hysteresis bits 1:0 go to the core.
// - disabled comparator drives its pin output low.
`timescale 1ns/10ps
module dcc_regs
    import dcc_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    // special function register port
    input  wire logic [dcc_pkg::AW-1:0] sfr_addr_i,
    input  wire logic [dcc_pkg::DW-1:0] sfr_wdata_i,
    input  wire logic                sfr_wr_i,
    input  wire logic                sfr_rd_i,
    output logic [dcc_pkg::DW-1:0]   sfr_rdata_o,
    // analog comparator cores
    input  wire logic                cmp_a_raw_i,
    input  wire logic                cmp_b_raw_i,
    output logic                     cmp_a_on_o,
    output logic [1:0]               cmp_a_pos_hyst_o,
    output logic [1:0]               cmp_a_neg_hyst_o,
    output logic [1:0]               cmp_a_speed_sel_o,
    output logic                     cmp_b_on_o,
    output logic [1:0]               cmp_b_pos_hyst_o,
    output logic [1:0]               cmp_b_neg_hyst_o,
    // port pin outputs and interrupt request
    output logic                     cmp_a_pin_o,
    output logic                     cmp_b_pin_o,
    output logic                     cmp_a_irq_o
);
    import dcc_pkg::*;

    dcc_edge_if a_if ();
    dcc_edge_if b_if ();

    logic       a_on_ff;
    logic [1:0] a_posh_ff;
    logic [1:0] a_negh_ff;
    logic       a_rise_ie_ff;
    logic       a_fall_ie_ff;
    logic [1:0] a_speed_ff;
    logic       b_on_ff;
    logic [1:0] b_posh_ff;
    logic [1:0] b_negh_ff;
    logic       a_pin_ff;
    logic       b_pin_ff;
    logic       a_irq_ff;
    logic [DW-1:0] rdata_ff;
    logic [DW-1:0] nxt_rdata;
    logic          wr_ctl0;
    logic          wr_mode0;
    logic          wr_ctl1;

    assign wr_ctl0  = sfr_wr_i && (sfr_addr_i == ADDR_CMP0_CONTROL);
    assign wr_mode0 = sfr_wr_i && (sfr_addr_i == ADDR_CMP0_MODE);
    assign wr_ctl1  = sfr_wr_i && (sfr_addr_i == ADDR_CMP1_CONTROL);

    dcc_edge_det u_edge_a (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .raw_i   (cmp_a_raw_i),
        .edge_if (a_if.det)
    );

    dcc_edge_det u_edge_b (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .raw_i   (cmp_b_raw_i),
        .edge_if (b_if.det)
    );

    // flag bits written through the control registers
    assign a_if.wr_flags = wr_ctl0;
    assign a_if.wr_rise  = sfr_wdata_i[CTL_RISE_BIT];
    assign a_if.wr_fall  = sfr_wdata_i[CTL_FALL_BIT];
    assign b_if.wr_flags = wr_ctl1;
    assign b_if.wr_rise  = sfr_wdata_i[CTL_RISE_BIT];
    assign b_if.wr_fall  = sfr_wdata_i[CTL_FALL_BIT];

    // comparator A control
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            a_on_ff   <= RST_CONTROL[CTL_ON_BIT];
            a_posh_ff <= RST_HYST;
            a_negh_ff <= RST_HYST;
        end else if (wr_ctl0) begin
            a_on_ff   <= sfr_wdata_i[CTL_ON_BIT];
            a_posh_ff <= sfr_wdata_i[CTL_POSH_MSB:CTL_POSH_LSB];
            a_negh_ff <= sfr_wdata_i[CTL_NEGH_MSB:CTL_NEGH_LSB];
        end
    end

    // comparator A mode; unused bits have no storage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            a_rise_ie_ff <= RST_MODE[MD_RISE_IE_BIT];
            a_fall_ie_ff <= RST_MODE[MD_FALL_IE_BIT];
            a_speed_ff   <= RST_SPEED;
        end else if (wr_mode0) begin
            a_rise_ie_ff <= sfr_wdata_i[MD_RISE_IE_BIT];
            a_fall_ie_ff <= sfr_wdata_i[MD_FALL_IE_BIT];
            a_speed_ff   <= sfr_wdata_i[MD_SPEED_MSB:MD_SPEED_LSB];
        end
    end

    // comparator B control
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            b_on_ff   <= RST_CONTROL[CTL_ON_BIT];
            b_posh_ff <= RST_HYST;
            b_negh_ff <= RST_HYST;
        end else if (wr_ctl1) begin
            b_on_ff   <= sfr_wdata_i[CTL_ON_BIT];
            b_posh_ff <= sfr_wdata_i[CTL_POSH_MSB:CTL_POSH_LSB];
            b_negh_ff <= sfr_wdata_i[CTL_NEGH_MSB:CTL_NEGH_LSB];
        end
    end

    // pin outputs held low while off; result only valid when powered
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            a_pin_ff <= 1'b0;
            b_pin_ff <= 1'b0;
        end else begin
            a_pin_ff <= a_on_ff & a_if.result;
            b_pin_ff <= b_on_ff & b_if.result;
        end
    end

    // request level follows the flags; software clears flags to drop it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            a_irq_ff <= 1'b0;
        end else begin
            a_irq_ff <= (a_if.rise_flag & a_rise_ie_ff)
                      | (a_if.fall_flag & a_fall_ie_ff);
        end
    end

    // read data registered: appears one cycle after the read strobe
    always_comb begin
        nxt_rdata = RD_UNMAPPED;
        unique case (sfr_addr_i)
            ADDR_CMP0_CONTROL: begin
                nxt_rdata = {a_on_ff, a_if.result, a_if.rise_flag,
                             a_if.fall_flag, a_posh_ff, a_negh_ff};
            end
            ADDR_CMP0_MODE: begin
                nxt_rdata = {2'h0, a_rise_ie_ff, a_fall_ie_ff, 2'h0, a_speed_ff};
            end
            ADDR_CMP1_CONTROL: begin
                nxt_rdata = {b_on_ff, b_if.result, b_if.rise_flag,
                             b_if.fall_flag, b_posh_ff, b_negh_ff};
            end
            default: begin
                nxt_rdata = RD_UNMAPPED;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= RD_UNMAPPED;
        end else if (sfr_rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata_o       = rdata_ff;
    assign cmp_a_on_o        = a_on_ff;
    assign cmp_a_pos_hyst_o  = a_posh_ff;
    assign cmp_a_neg_hyst_o  = a_negh_ff;
    assign cmp_a_speed_sel_o = a_speed_ff;
    assign cmp_b_on_o        = b_on_ff;
    assign cmp_b_pos_hyst_o  = b_posh_ff;
    assign cmp_b_neg_hyst_o  = b_negh_ff;
    assign cmp_a_pin_o       = a_pin_ff;
    assign cmp_b_pin_o       = b_pin_ff;
    assign cmp_a_irq_o       = a_irq_ff;

    sequence s_write_ctl0;
        sfr_wr_i && sfr_addr_i == ADDR_CMP0_CONTROL;
    endsequence

    sequence s_read_mode0;
        sfr_rd_i && sfr_addr_i == ADDR_CMP0_MODE;
    endsequence

    a_enable_follows: assert property (@(posedge clk_i) disable iff (reset_i)
        s_write_ctl0 |=> cmp_a_on_o == $past(sfr_wdata_i[CTL_ON_BIT]))
        else $error("enable not taken from write");
    a_result_readback: assert property (@(posedge clk_i) disable iff (reset_i)
        (sfr_rd_i && sfr_addr_i == ADDR_CMP0_CONTROL) |=>
        sfr_rdata_o[CTL_RESULT_BIT] == $past(a_if.result))
        else $error("result bit mismatch");
    a_mode_unused_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        s_read_mode0 |=> sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[3:2] == 2'h0)
        else $error("unused mode bits not zero");
    a_speed_reset: assert property (@(posedge clk_i)
        $fell(reset_i) |-> cmp_a_speed_sel_o == 2'h2)
        else $error("speed select reset value wrong");
    a_irq_rise_on: assert property (@(posedge clk_i) disable iff (reset_i)
        (a_if.rise_flag && a_rise_ie_ff) |=> cmp_a_irq_o)
        else $error("rise request missing");
    a_irq_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        !(a_if.rise_flag && a_rise_ie_ff) && !(a_if.fall_flag && a_fall_ie_ff)
        |=> !cmp_a_irq_o) else $error("request without enabled flag");
    a_pin_low_off: assert property (@(posedge clk_i) disable iff (reset_i)
        !b_on_ff |=> !cmp_b_pin_o) else $error("disabled pin not low");
    a_clear_loses_race: assert property (@(posedge clk_i) disable iff (reset_i)
        (s_write_ctl0 ##0 (a_if.rise_evt || a_if.fall_evt)) |=>
        (a_if.rise_flag || !$past(a_if.rise_evt)) && (a_if.fall_flag || !$past(a_if.fall_evt)))
        else $error("edge lost under clear");
    a_hyst_b_follows: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_ctl1 |=> cmp_b_neg_hyst_o == $past(sfr_wdata_i[1:0]))
        else $error("hysteresis b not taken");
endmodule

/* tb/dcc_cmp_model.sv */
// behavioural model of one analog comparator core
`timescale 1ns/10ps
module dcc_cmp_model (
    // control from the register bank
    input  wire logic       on_i,
    input  wire logic [1:0] speed_i,
    // 1 while the positive input is above the negative input
    input  wire logic       vin_i,
    // raw comparator output, asynchronous
    output logic            raw_o
);
    // slower modes answer later; a powered-down core reads low
    // one process drives the output, so it has a single driver
    initial begin
        raw_o = 1'b0;
        forever begin
            @(on_i or vin_i or speed_i);
            raw_o <= #(3.0 + 20.0 * speed_i) (on_i & vin_i);
        end
    end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the dual comparator control registers
`timescale 1ns/10ps
module tb_top;
    import dcc_pkg::*;
    logic          clk_i = 1'b0;
    logic          reset_i = 1'b1;
    logic [AW-1:0] sfr_addr_i = '0;
    logic [DW-1:0] sfr_wdata_i = '0;
    logic          sfr_wr_i = 1'b0;
    logic          sfr_rd_i = 1'b0;
    logic [DW-1:0] sfr_rdata_o;
    logic          vin_a = 1'b0;
    logic          vin_b = 1'b0;
    logic          a_raw, b_raw, a_on, b_on, a_pin, b_pin, a_irq;
    logic [1:0]    a_ph, a_nh, a_sp, b_ph, b_nh;
    int            failures = 0;
    int            checks_done = 0;
    int            ctl_m [2] = '{0, 0};
    int            res_m [2] = '{0, 0};
    int            md_m = 2;
    int            hits;

    always #12.5 clk_i = ~clk_i;

    dcc_regs uut (.clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o), .cmp_a_raw_i(a_raw), .cmp_b_raw_i(b_raw),
        .cmp_a_on_o(a_on), .cmp_a_pos_hyst_o(a_ph), .cmp_a_neg_hyst_o(a_nh),
        .cmp_a_speed_sel_o(a_sp), .cmp_b_on_o(b_on), .cmp_b_pos_hyst_o(b_ph),
        .cmp_b_neg_hyst_o(b_nh), .cmp_a_pin_o(a_pin), .cmp_b_pin_o(b_pin),
        .cmp_a_irq_o(a_irq));
    dcc_cmp_model cmp_a (.on_i(a_on), .speed_i(a_sp), .vin_i(vin_a), .raw_o(a_raw));
    dcc_cmp_model cmp_b (.on_i(b_on), .speed_i(2'h1), .vin_i(vin_b), .raw_o(b_raw));

    task automatic check(input logic [7:0] got, input int exp, input string what);
        checks_done++;
        if (got !== exp[7:0]) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp[7:0]);
        end
    endtask

    // edge bookkeeping of the reference model
    task automatic upd(input int i, input logic v);
        int n;
        n = ((ctl_m[i] >> 7) & 1) & int'(v);
        if (n > res_m[i]) ctl_m[i] |= 32'h20;
        if (n < res_m[i]) ctl_m[i] |= 32'h10;
        res_m[i] = n;
    endtask

    // bus tasks start and end 1 ns after a rising edge; an idle edge after each
    // transfer keeps a strobe from being lowered and raised in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(posedge clk_i);
        #1;
        sfr_wr_i = 1'b0;
        if (a == ADDR_CMP0_CONTROL) ctl_m[0] = int'(d) & 32'hbf;
        if (a == ADDR_CMP1_CONTROL) ctl_m[1] = int'(d) & 32'hbf;
        if (a == ADDR_CMP0_MODE) md_m = int'(d) & 32'h33;
        upd(0, vin_a);
        upd(1, vin_b);
        @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input int exp);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(posedge clk_i);
        #1;
        sfr_rd_i = 1'b0;
        check(sfr_rdata_o, exp, "register read");
        @(posedge clk_i);
        #1;
    endtask

    // worst-case analog delay plus synchroniser and flag stages
    task automatic settle;
        repeat (12) @(posedge clk_i);
        #1;
    endtask

    task automatic setv(input int i, input logic v);
        if (i == 0) vin_a = v;
        else vin_b = v;
        upd(i, v);
        settle();
    endtask

    task automatic chk_all;
        int irq;
        int exp_a;
        int exp_b;
        irq = ((md_m >> 5) & (ctl_m[0] >> 5) & 1) | ((md_m >> 4) & (ctl_m[0] >> 4) & 1);
        exp_a = ((ctl_m[0] & 15) << 4) | ((md_m & 3) << 2) | ((ctl_m[0] >> 7) << 1) | res_m[0];
        exp_b = ((ctl_m[1] & 15) << 4) | ((ctl_m[1] >> 7) << 3) | (res_m[1] << 2) | (irq << 1);
        rd(ADDR_CMP0_CONTROL, ctl_m[0] | (res_m[0] << 6));
        rd(ADDR_CMP1_CONTROL, ctl_m[1] | (res_m[1] << 6));
        rd(ADDR_CMP0_MODE, md_m);
        rd(8'h9c, 0);
        check({a_ph, a_nh, a_sp, a_on, a_pin}, exp_a,
              "outputs a");
        check({b_ph, b_nh, b_on, b_pin, a_irq, 1'b0}, exp_b,
              "outputs b");
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        failures++;
        test_done();
    end

    initial begin
        void'($urandom(42));
        repeat (6) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        chk_all();
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CMP0_CONTROL, {4'h0, k[1:0], 2'(3 - k)});
            wr(ADDR_CMP1_CONTROL, {4'h0, 2'(3 - k), k[1:0]});
            wr(ADDR_CMP0_MODE, 8'(($urandom & 32'hcc) | k));
            wr(8'h9c, 8'($urandom));
            chk_all();
        end
        wr(ADDR_CMP0_MODE, 8'h31);
        wr(ADDR_CMP0_CONTROL, 8'h80);
        settle();
        setv(0, 1'b1);
        chk_all();
        wr(ADDR_CMP0_CONTROL, 8'h80);
        chk_all();
        setv(0, 1'b0);
        chk_all();
        wr(ADDR_CMP0_MODE, 8'h02);
        chk_all();
        setv(0, 1'b1);
        wr(ADDR_CMP0_CONTROL, 8'h00);
        settle();
        chk_all();
        wr(ADDR_CMP1_CONTROL, 8'h30);
        chk_all();
        wr(ADDR_CMP1_CONTROL, 8'h80);
        settle();
        setv(1, 1'b1);
        chk_all();
        wr(ADDR_CMP1_CONTROL, 8'h80);
        setv(1, 1'b0);
        chk_all();
        wr(ADDR_CMP1_CONTROL, 8'h00);
        chk_all();
        // clearing writes on every edge while the result rises
        vin_a = 1'b0;
        res_m[0] = 0;
        wr(ADDR_CMP0_CONTROL, 8'h80);
        wr(ADDR_CMP0_MODE, 8'h20);
        settle();
        wr(ADDR_CMP0_CONTROL, 8'h80);
        vin_a = 1'b1;
        res_m[0] = 1;
        sfr_addr_i = ADDR_CMP0_CONTROL;
        sfr_wdata_i = 8'h80;
        sfr_wr_i = 1'b1;
        hits = 0;
        repeat (10) begin
            @(posedge clk_i);
            #1;
            hits += int'(a_irq === 1'b1);
        end
        sfr_wr_i = 1'b0;
        check(8'(hits > 0), 1, "edge during clearing write");
        settle();
        chk_all();
        test_done();
    end
endmodule
